// ===== bench/lapd_peer.sv
// Far-side transmitter model that ends each offered frame after a delay.
`timescale 1ns/1ps
module lapd_peer (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       tx_valid,
    input  wire logic [3:0] dly,
    output logic            tx_done
);
    logic [3:0] cnt;

    // The delay input lets the bench mix prompt and slow line rates.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            tx_done <= 1'b0;
        end else if (tx_valid && !tx_done && cnt >= dly) begin
            cnt <= 4'h0;
            tx_done <= 1'b1;
        end else begin
            cnt <= (tx_valid && !tx_done) ? cnt + 4'h1 : 4'h0;
            tx_done <= 1'b0;
        end
    end
endmodule

// ===== bench/tb_lapd_mft.sv
// Self-checking bench for the multiple-frame transfer entity.
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, a); end end
`define WAITC(c) begin wt = 0; do begin @(posedge sys_clk); wt++; end \
    while (!(c) && wt < 500); if (wt >= 500) complete_run(1); end
module tb_lapd_mft import lapd_pkg::*;;
    logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, dl_data, dl_ind_data, rx_data, tx_data;
    logic [31:0] pwdata, prdata;
    logic        dl_est_req, dl_rel_req, dl_data_req, dl_data_ack, dl_ind;
    logic        dl_est_ind, dl_est_conf, dl_rel_ind, dl_rel_conf, mdl_err;
    logic        rx_valid, rx_cmd, rx_pf, tx_valid, tx_cmd, tx_pf, tx_done;
    lapd_ft_e    rx_type, tx_type;
    lapd_seq_t   rx_ns, rx_nr, tx_ns, tx_nr;
    logic [5:0]  evt;
    logic [3:0]  dly;
    int          error_cnt, samples_checked, wt;

    lapd_mft #(.T200_CYC(200)) u_lapd_mft (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .dl_est_req  (dl_est_req),
        .dl_rel_req  (dl_rel_req),
        .dl_data_req (dl_data_req),
        .dl_data     (dl_data),
        .dl_data_ack (dl_data_ack),
        .dl_ind      (dl_ind),
        .dl_ind_data (dl_ind_data),
        .dl_est_ind  (dl_est_ind),
        .dl_est_conf (dl_est_conf),
        .dl_rel_ind  (dl_rel_ind),
        .dl_rel_conf (dl_rel_conf),
        .mdl_err     (mdl_err),
        .rx_valid    (rx_valid),
        .rx_type     (rx_type),
        .rx_cmd      (rx_cmd),
        .rx_pf       (rx_pf),
        .rx_ns       (rx_ns),
        .rx_nr       (rx_nr),
        .rx_data     (rx_data),
        .tx_valid    (tx_valid),
        .tx_type     (tx_type),
        .tx_cmd      (tx_cmd),
        .tx_pf       (tx_pf),
        .tx_ns       (tx_ns),
        .tx_nr       (tx_nr),
        .tx_data     (tx_data),
        .tx_done     (tx_done)
    );
    lapd_peer u_lapd_peer (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .tx_valid (tx_valid),
        .dly      (dly),
        .tx_done  (tx_done)
    );

    always #5 sys_clk = ~sys_clk;
    // Pulses are folded into sticky bits so a check never races a pulse.
    always @(posedge sys_clk)
        evt <= evt | {mdl_err, dl_rel_conf, dl_rel_ind, dl_est_conf,
                      dl_est_ind, dl_ind};

    task automatic complete_run(input bit tmo);
        error_cnt += tmo;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, exp, input logic serr);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        `WAITC(pready === 1'b1)
        if (!w) `CHK("prdata", exp, prdata)
        `CHK("pslverr", serr, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic send(input logic [7:0] b);
        dl_data_req <= 1'b1;
        dl_data <= b;
        `WAITC(dl_data_ack === 1'b1)
        dl_data_req <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rx(input lapd_ft_e t, input logic c, p,
                      input lapd_seq_t ns, nr);
        rx_valid <= 1'b1;
        rx_type <= t;
        rx_cmd <= c;
        rx_pf <= p;
        rx_ns <= ns;
        rx_nr <= nr;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic txw(input lapd_ft_e t, input logic p,
                       input lapd_seq_t ns, nr);
        `WAITC(tx_valid === 1'b1 && tx_done === 1'b1)
        `CHK("tx_type", t, tx_type)
        `CHK("tx_pf", p, tx_pf)
        if (t == FT_I) `CHK("tx_ns", ns, tx_ns)
        if (t == FT_I) `CHK("tx_data", 8'ha1 + ns, tx_data)
        `CHK("tx_cmd", t inside {FT_I, FT_SABME, FT_DISC}, tx_cmd)
        if (t < FT_SABME) `CHK("tx_nr", nr, tx_nr)
    endtask

    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, dl_est_req, dl_rel_req,
         dl_data_req, dl_data, rx_valid, rx_cmd, rx_pf, rx_ns, rx_nr} = '0;
        rx_type = FT_RR;
        rx_data = 8'h5a;
        dly = 4'h1;
        evt = '0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(1'b0, 8'h04, 32'h0, 32'h307, 1'b0);
        apb(1'b1, 8'h04, 32'h301, 32'h0, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
        $display("test registers done");
        dl_est_req <= 1'b1;
        @(posedge sys_clk);
        dl_est_req <= 1'b0;
        txw(FT_SABME, 1'b1, 0, 0);
        rx(FT_SABME, 1'b1, 1'b1, 0, 0);
        txw(FT_UA, 1'b1, 0, 0);
        apb(1'b0, 8'h08, 32'h0, 32'h01000000, 1'b0);
        rx(FT_UA, 1'b0, 1'b1, 0, 0);
        `CHK("events", 6'h04, evt)
        $display("test collision done");
        dly <= 4'h6;
        send(8'ha1);
        send(8'ha2);
        txw(FT_I, 1'b0, 0, 0);
        repeat (20) @(posedge sys_clk);
        `CHK("tx_valid", 1'b0, tx_valid)
        rx(FT_I, 1'b1, 1'b1, 0, 1);
        `CHK("events", 6'h05, evt)
        `CHK("ind_data", 8'h5a, dl_ind_data)
        txw(FT_RR, 1'b1, 0, 1);
        txw(FT_I, 1'b0, 1, 1);
        rx(FT_REJ, 1'b0, 1'b0, 0, 1);
        txw(FT_I, 1'b0, 1, 1);
        apb(1'b0, 8'h08, 32'h0, 32'h03010102, 1'b0);
        rx(FT_RR, 1'b0, 1'b0, 0, 2);
        apb(1'b0, 8'h08, 32'h0, 32'h03020102, 1'b0);
        rx(FT_REJ, 1'b0, 1'b1, 0, 2);
        `CHK("events", 6'h25, evt)
        $display("test transfer done");
        dl_rel_req <= 1'b1;
        @(posedge sys_clk);
        dl_rel_req <= 1'b0;
        txw(FT_DISC, 1'b1, 0, 0);
        rx(FT_DM, 1'b0, 1'b0, 0, 0);
        apb(1'b0, 8'h08, 32'h0, 32'h02020102, 1'b0);
        rx(FT_DM, 1'b0, 1'b1, 0, 0);
        `CHK("events", 6'h35, evt)
        $display("test release done");
        complete_run(0);
    end
endmodule

// ===== hw/lapd_defines.svh
// Offsets, field positions, reset values and timing counts of the link entity.
// How it works
// - Same crossing SABME or DISC: send UA, enter state on peer UA.
// - Different crossing commands: send DM; DM F=1 gives TEI-assigned.
// - Every SABME or DISC we send carries P set to one.
// - DM with F=0 while our mode command is outstanding is ignored.
// - Data goes out as I frame N(S)=V(S), N(R)=V(R); V(S) steps after.
// - Sending an I frame starts T200 when it is idle.
// - No new I frame once V(S)=V(A)+k; retransmissions still allowed.
// - Own receiver busy does not stop our I frames.
// - Data requests during timer recovery are queued.
// - In-sequence I frame while not busy is delivered and V(R) steps.
// - In-sequence I frame with P=1 is answered RR or RNR with F=1.
// - With P=0 answer RR F=0 if nothing sendable, RNR F=0 if busy.
// - N(R) of every sent I or supervisory frame is current V(R).
// - Valid received N(R) acknowledges frames below it; V(A) takes N(R).
// - T200 resets on advancing N(R) in I, RR or RNR frames, with exceptions; REJ never resets it.
// - After a non-REJ reset, T200 restarts while frames stay unacked.
// - REJ: clear peer busy, rewind V(S), stop T200, answer poll.
// - REJ response with F=1 outside recovery raises an error indication.
// - REJ response F=1 in recovery rewinds, stops T200, leaves recovery.
// - Other REJ in recovery clears peer busy, loads V(A), answers poll.
// - Resend waits for a supervisory frame, is dropped under U frames.
// - All unacknowledged frames resend in order, then new ones follow.
// - No I frames while the peer signals receiver busy.
// - T200 expiry: recovery, poll below N200, re-establish at N200.
// - Sequence numbers wrap modulo 128.
`ifndef LAPD_DEFINES_SVH
`define LAPD_DEFINES_SVH

`define LAPD_OFF_CTRL   8'h00
`define LAPD_OFF_CFG    8'h04
`define LAPD_OFF_STAT   8'h08

`define LAPD_CTRL_BUSY  0
`define LAPD_CFG_K      6:0
`define LAPD_CFG_N200   11:8
`define LAPD_STAT_VS    6:0
`define LAPD_STAT_VR    14:8
`define LAPD_STAT_VA    22:16
`define LAPD_STAT_ST    26:24
`define LAPD_STAT_PB    28

`define LAPD_K_RST      7'h07
`define LAPD_N200_RST   4'h3
`define LAPD_SEQ_FULL   7'h7f

`define LAPD_CLK_KHZ    100000
`define LAPD_T200_MS    1000
`define LAPD_T200_CYC   (`LAPD_T200_MS * `LAPD_CLK_KHZ)

`endif

// ===== hw/lapd_mft.sv
// Multiple-frame transfer entity: mode setting, I frames, acks, T200, REJ.
`timescale 1ns/1ps
`include "lapd_defines.svh"
module lapd_mft import lapd_pkg::*; #(
    parameter int unsigned T200_CYC = `LAPD_T200_CYC
) (
    input  wire logic      sys_clk,
    input  wire logic      rstn,
    input  wire logic      psel,
    input  wire logic      penable,
    input  wire logic      pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]    prdata,
    output logic           pready,
    output logic           pslverr,
    input  wire logic      dl_est_req,
    input  wire logic      dl_rel_req,
    input  wire logic      dl_data_req,
    input  wire logic [7:0] dl_data,
    output logic           dl_data_ack,
    output logic           dl_ind,
    output logic [7:0]     dl_ind_data,
    output logic           dl_est_ind,
    output logic           dl_est_conf,
    output logic           dl_rel_ind,
    output logic           dl_rel_conf,
    output logic           mdl_err,
    input  wire logic      rx_valid,
    input  wire lapd_ft_e  rx_type,
    input  wire logic      rx_cmd,
    input  wire logic      rx_pf,
    input  wire lapd_seq_t rx_ns,
    input  wire lapd_seq_t rx_nr,
    input  wire logic [7:0] rx_data,
    output logic           tx_valid,
    output lapd_ft_e       tx_type,
    output logic           tx_cmd,
    output logic           tx_pf,
    output lapd_seq_t      tx_ns,
    output lapd_seq_t      tx_nr,
    output logic [7:0]     tx_data,
    input  wire logic      tx_done
);
    // Sequence space is 7 bits, so all sums wrap by width.
    function automatic lapd_seq_t seq_add(lapd_seq_t a, lapd_seq_t b);
        return lapd_seq_t'(a + b);
    endfunction
    function automatic lapd_seq_t seq_dist(lapd_seq_t a, lapd_seq_t b);
        return lapd_seq_t'(b - a);
    endfunction

    logic        own_busy;
    lapd_seq_t   cfg_k;
    logic [3:0]  cfg_n200;
    lapd_ls_e    state;
    lapd_seq_t   vs, vr, va, hi, tail;
    logic        peer_busy, poll_out;
    logic [3:0]  rc;
    logic        t200_run;
    logic [31:0] t200_cnt;
    logic        pend_u, pend_u_cmd, pend_u_pf;
    lapd_ft_e    pend_u_type;
    logic        pend_s, pend_s_cmd, pend_s_pf;
    lapd_ft_e    pend_s_type;
    logic [7:0]  qmem [0:127];
    logic [31:0] rd_mux;
    logic        hit, acc, in_mf, numb, nr_ok, i_avail, rej_ok, expire;
    logic        t_rst;
    lapd_ft_e    s_kind;

    // APB slave: pready rises one cycle into the access phase.
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            `LAPD_OFF_CTRL: rd_mux[`LAPD_CTRL_BUSY] = own_busy;
            `LAPD_OFF_CFG: begin
                rd_mux[`LAPD_CFG_K] = cfg_k;
                rd_mux[`LAPD_CFG_N200] = cfg_n200;
            end
            `LAPD_OFF_STAT: begin
                rd_mux[`LAPD_STAT_VS] = vs;
                rd_mux[`LAPD_STAT_VR] = vr;
                rd_mux[`LAPD_STAT_VA] = va;
                rd_mux[`LAPD_STAT_ST] = state;
                rd_mux[`LAPD_STAT_PB] = peer_busy;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            own_busy <= 1'b0;
            cfg_k <= `LAPD_K_RST;
            cfg_n200 <= `LAPD_N200_RST;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready)
                prdata <= hit && !pwrite ? rd_mux : 32'h0;
            if (psel && penable && pready && pwrite) begin
                if (paddr == `LAPD_OFF_CTRL)
                    own_busy <= pwdata[`LAPD_CTRL_BUSY];
                if (paddr == `LAPD_OFF_CFG) begin
                    cfg_k <= pwdata[`LAPD_CFG_K];
                    cfg_n200 <= pwdata[`LAPD_CFG_N200];
                end
            end
        end
    end

    always_comb begin
        in_mf = state == LS_EST || state == LS_TR;
        numb = rx_type inside {FT_I, FT_RR, FT_RNR, FT_REJ};
        nr_ok = seq_dist(va, rx_nr) <= seq_dist(va, hi);
        // Requests are taken in recovery too; they wait in the queue.
        acc = dl_data_req && !dl_data_ack && in_mf
              && seq_add(tail, 7'h01) != va;
        // A frame behind hi is a retransmission and ignores the window.
        i_avail = state == LS_EST && vs != tail && !peer_busy
                  && (vs != hi || seq_dist(va, vs) < cfg_k);
        s_kind = own_busy ? FT_RNR : FT_RR;
        rej_ok = !(tx_valid && tx_type inside
                   {FT_SABME, FT_DISC, FT_UA, FT_DM});
        expire = t200_run && t200_cnt == T200_CYC - 1;
        t_rst = (rx_nr != va && !poll_out
                 && !(rx_type == FT_I && peer_busy))
                || (rx_type == FT_REJ && rx_nr == va);
    end

    // Queue and retransmission store, indexed by sequence number.
    always_ff @(posedge sys_clk) begin
        if (acc)
            qmem[tail] <= dl_data;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= LS_TEI;
            {vs, vr, va, hi, tail} <= '0;
            peer_busy <= 1'b0;
            poll_out <= 1'b0;
            rc <= 4'h0;
            t200_run <= 1'b0;
            t200_cnt <= 32'h0;
            pend_u <= 1'b0;
            pend_u_type <= FT_UA;
            pend_u_cmd <= 1'b0;
            pend_u_pf <= 1'b0;
            pend_s <= 1'b0;
            pend_s_type <= FT_RR;
            pend_s_cmd <= 1'b0;
            pend_s_pf <= 1'b0;
            tx_valid <= 1'b0;
            tx_type <= FT_RR;
            tx_cmd <= 1'b0;
            tx_pf <= 1'b0;
            tx_ns <= '0;
            tx_nr <= '0;
            tx_data <= 8'h00;
            dl_data_ack <= 1'b0;
            dl_ind <= 1'b0;
            dl_ind_data <= 8'h00;
            dl_est_ind <= 1'b0;
            dl_est_conf <= 1'b0;
            dl_rel_ind <= 1'b0;
            dl_rel_conf <= 1'b0;
            mdl_err <= 1'b0;
        end else begin
            dl_data_ack <= acc;
            dl_ind <= 1'b0;
            dl_est_ind <= 1'b0;
            dl_est_conf <= 1'b0;
            dl_rel_ind <= 1'b0;
            dl_rel_conf <= 1'b0;
            mdl_err <= 1'b0;
            if (acc)
                tail <= seq_add(tail, 7'h01);
            if (t200_run)
                t200_cnt <= t200_cnt + 32'h1;

            // Transmitter: hold a frame until tx_done, then pick the next.
            if (tx_valid && tx_done) begin
                tx_valid <= 1'b0;
                if (tx_type == FT_I) begin
                    if (vs == tx_ns)
                        vs <= seq_add(vs, 7'h01);
                    if (hi == tx_ns)
                        hi <= seq_add(hi, 7'h01);
                end
            end else if (!tx_valid) begin
                tx_nr <= vr;
                if (pend_u) begin
                    tx_valid <= 1'b1;
                    pend_u <= 1'b0;
                    tx_type <= pend_u_type;
                    tx_cmd <= pend_u_cmd;
                    tx_pf <= pend_u_pf;
                end else if (pend_s) begin
                    tx_valid <= 1'b1;
                    pend_s <= 1'b0;
                    tx_type <= pend_s_type;
                    tx_cmd <= pend_s_cmd;
                    tx_pf <= pend_s_pf;
                end else if (i_avail) begin
                    // Walks vs up to hi first, then on to new frames.
                    tx_valid <= 1'b1;
                    tx_type <= FT_I;
                    tx_cmd <= 1'b1;
                    tx_pf <= 1'b0;
                    tx_ns <= vs;
                    tx_data <= qmem[vs];
                    if (!t200_run) begin
                        t200_run <= 1'b1;
                        t200_cnt <= 32'h0;
                    end
                end
            end

            // Layer 3 mode requests.
            if (dl_est_req && state == LS_TEI) begin
                pend_u <= 1'b1;
                pend_u_type <= FT_SABME;
                pend_u_cmd <= 1'b1;
                pend_u_pf <= 1'b1;
                state <= LS_AWAIT_EST;
                rc <= 4'h0;
                t200_run <= 1'b1;
                t200_cnt <= 32'h0;
            end else if (dl_rel_req && in_mf) begin
                pend_u <= 1'b1;
                pend_u_type <= FT_DISC;
                pend_u_cmd <= 1'b1;
                pend_u_pf <= 1'b1;
                state <= LS_AWAIT_REL;
                rc <= 4'h0;
                t200_run <= 1'b1;
                t200_cnt <= 32'h0;
            end

            if (expire) begin
                t200_cnt <= 32'h0;
                case (state)
                    LS_AWAIT_EST, LS_AWAIT_REL: begin
                        if (rc == cfg_n200) begin
                            mdl_err <= 1'b1;
                            dl_rel_ind <= state == LS_AWAIT_EST;
                            dl_rel_conf <= state == LS_AWAIT_REL;
                            state <= LS_TEI;
                            t200_run <= 1'b0;
                        end else begin
                            rc <= rc + 4'h1;
                            pend_u <= 1'b1;
                            pend_u_cmd <= 1'b1;
                            pend_u_pf <= 1'b1;
                            pend_u_type <= state == LS_AWAIT_EST
                                           ? FT_SABME : FT_DISC;
                        end
                    end
                    LS_EST, LS_TR: begin
                        if (state == LS_TR && rc + 4'h1 >= cfg_n200) begin
                            mdl_err <= 1'b1;
                            state <= LS_AWAIT_EST;
                            rc <= 4'h0;
                            poll_out <= 1'b0;
                            pend_u <= 1'b1;
                            pend_u_type <= FT_SABME;
                            pend_u_cmd <= 1'b1;
                            pend_u_pf <= 1'b1;
                        end else begin
                            rc <= state == LS_TR ? rc + 4'h1 : 4'h0;
                            state <= LS_TR;
                            poll_out <= 1'b1;
                            pend_s <= 1'b1;
                            pend_s_type <= s_kind;
                            pend_s_cmd <= 1'b1;
                            pend_s_pf <= 1'b1;
                        end
                    end
                    default: t200_run <= 1'b0;
                endcase
            end

            if (rx_valid && numb && in_mf && nr_ok) begin
                va <= rx_nr;
                if (rx_type == FT_RNR)
                    peer_busy <= 1'b1;
                else if (rx_type != FT_I)
                    peer_busy <= 1'b0;
                if (t_rst && rx_type != FT_REJ) begin
                    t200_cnt <= 32'h0;
                    t200_run <= rx_nr != hi;
                end
                if (rx_type == FT_I) begin
                    if (!own_busy && rx_ns == vr) begin
                        vr <= seq_add(vr, 7'h01);
                        dl_ind <= 1'b1;
                        dl_ind_data <= rx_data;
                    end
                    // Own busy still sends I frames; only peer busy stops.
                    if (rx_pf || own_busy || !i_avail) begin
                        pend_s <= 1'b1;
                        pend_s_type <= s_kind;
                        pend_s_cmd <= 1'b0;
                        pend_s_pf <= rx_pf;
                    end
                end else if (rx_cmd && rx_pf) begin
                    pend_s <= 1'b1;
                    pend_s_type <= s_kind;
                    pend_s_cmd <= 1'b0;
                    pend_s_pf <= 1'b1;
                end
                if (state == LS_TR && rx_type inside {FT_RR, FT_RNR}
                    && !rx_cmd && rx_pf) begin
                    state <= LS_EST;
                    vs <= rx_nr;
                    poll_out <= 1'b0;
                    t200_cnt <= 32'h0;
                    t200_run <= rx_type == FT_RNR || rx_nr != hi;
                end
                if (rx_type == FT_REJ) begin
                    if (state == LS_EST) begin
                        if (rej_ok)
                            vs <= rx_nr;
                        t200_run <= 1'b0;
                        mdl_err <= !rx_cmd && rx_pf;
                    end else if (!rx_cmd && rx_pf) begin
                        if (rej_ok)
                            vs <= rx_nr;
                        t200_run <= 1'b0;
                        state <= LS_EST;
                        poll_out <= 1'b0;
                    end
                    // Any other REJ in recovery only clears peer busy, updates V(A) and answers a poll above.
                end
            end

            if (rx_valid && !numb) begin
                case (rx_type)
                    FT_SABME, FT_DISC: begin
                        pend_u <= 1'b1;
                        pend_u_cmd <= 1'b0;
                        pend_u_pf <= rx_pf;
                        pend_u_type <= FT_UA;
                        if (state == LS_AWAIT_EST)
                            pend_u_type <= rx_type == FT_SABME
                                           ? FT_UA : FT_DM;
                        else if (state == LS_AWAIT_REL)
                            pend_u_type <= rx_type == FT_DISC
                                           ? FT_UA : FT_DM;
                        else if (rx_type == FT_SABME) begin
                            {vs, vr, va, hi, tail} <= '0;
                            state <= LS_EST;
                            dl_est_ind <= 1'b1;
                            peer_busy <= 1'b0;
                            poll_out <= 1'b0;
                            t200_run <= 1'b0;
                        end else if (in_mf) begin
                            state <= LS_TEI;
                            dl_rel_ind <= 1'b1;
                            t200_run <= 1'b0;
                        end else
                            pend_u_type <= FT_DM;
                    end
                    FT_UA, FT_DM: begin
                        // DM with F=0 may be a crossing; ignore it.
                        if (rx_pf && state == LS_AWAIT_EST) begin
                            t200_run <= 1'b0;
                            if (rx_type == FT_UA) begin
                                {vs, vr, va, hi, tail} <= '0;
                                state <= LS_EST;
                                dl_est_conf <= 1'b1;
                            end else begin
                                state <= LS_TEI;
                                dl_rel_ind <= 1'b1;
                            end
                        end else if (rx_pf && state == LS_AWAIT_REL) begin
                            t200_run <= 1'b0;
                            state <= LS_TEI;
                            dl_rel_conf <= 1'b1;
                        end else if (rx_type == FT_UA && state == LS_TEI)
                            mdl_err <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_mode_pbit: assert property ($rose(tx_valid) && tx_cmd
        && tx_type inside {FT_SABME, FT_DISC} |-> tx_pf)
        else $error("mode command sent without P bit");
    a_ifr_nr: assert property ($rose(tx_valid) && tx_type == FT_I
        |-> tx_nr == $past(vr) && tx_ns == $past(vs) && t200_run)
        else $error("I frame fields or T200 start wrong");
    a_vs_step: assert property (tx_valid && tx_done && tx_type == FT_I
        && vs == tx_ns && !rx_valid |=> vs == seq_add($past(vs), 7'h01))
        else $error("V(S) did not advance after I frame");
    a_window_busy: assert property ($rose(tx_valid) && tx_type == FT_I
        |-> !$past(peer_busy) && ($past(hi) != tx_ns
            || seq_dist($past(va), tx_ns) < cfg_k))
        else $error("I frame sent past window or to busy peer");
    a_rx_deliver: assert property (rx_valid && rx_type == FT_I && in_mf
        && nr_ok && !own_busy && rx_ns == vr
        |=> dl_ind && vr == seq_add($past(vr), 7'h01) ##1 !dl_ind)
        else $error("in-sequence I frame not delivered");
    a_dm_f0_ign: assert property (rx_valid && rx_type == FT_DM && !rx_pf
        && state inside {LS_AWAIT_EST, LS_AWAIT_REL} && !expire
        && !dl_rel_req |=> $stable(state))
        else $error("DM with F=0 changed state");
    a_ack_va: assert property (rx_valid && numb && in_mf && nr_ok
        |=> va == $past(rx_nr))
        else $error("V(A) not loaded from N(R)");
    a_rej_stop: assert property (rx_valid && rx_type == FT_REJ
        && state == LS_EST && nr_ok |=> !t200_run && !peer_busy)
        else $error("REJ did not stop T200 or clear peer busy");
    a_rej_err: assert property (rx_valid && rx_type == FT_REJ && !rx_cmd
        && rx_pf && state == LS_EST && nr_ok |=> mdl_err ##1 !mdl_err)
        else $error("REJ response F=1 gave no error pulse");
    a_tr_exit: assert property (rx_valid && rx_type == FT_REJ && !rx_cmd
        && rx_pf && state == LS_TR && nr_ok && !expire
        |=> state == LS_EST && !poll_out)
        else $error("REJ F=1 did not end recovery");

    c_est: cover property (state == LS_AWAIT_EST ##[1:20] state == LS_EST);
    c_rej: cover property (rx_valid && rx_type == FT_REJ && state == LS_EST);
    c_tr: cover property (state == LS_EST ##1 state == LS_TR);
endmodule

// ===== hw/lapd_pkg.sv
// Types shared by the link entity and its surroundings.
package lapd_pkg;
    typedef logic [6:0] lapd_seq_t;
    typedef enum logic [2:0] {
        FT_I, FT_RR, FT_RNR, FT_REJ, FT_SABME, FT_DISC, FT_UA, FT_DM
    } lapd_ft_e;
    typedef enum logic [2:0] {
        LS_TEI, LS_AWAIT_EST, LS_AWAIT_REL, LS_EST, LS_TR
    } lapd_ls_e;
endpackage
